// file: dam_pkg.sv
/*
 * Shared constants and types for the dual-channel muxed-output converter model.
 * Assumes a single system clock, much faster than the converter clock pin it samples.
 */
package dam_pkg;

   // Word widths
   localparam int DAM_RAW_W = 9;                  // Raw corrected stage sum, signed
   localparam int DAM_CODE_W = 8;                 // Output code width
   localparam int DAM_PAIR_W = 2 * DAM_CODE_W;    // Both channels side by side

   // Pipeline latency in converter half periods, output latch included
   localparam int DAM_LAT_FIRST_CYC = 5;          // First channel, whole cycles
   localparam int DAM_LAT_FIRST_HALF = 2 * DAM_LAT_FIRST_CYC;
   localparam int DAM_LAT_SECOND_HALF = DAM_LAT_FIRST_HALF + 1;  // 5.5 cycles
   localparam int DAM_PIPE_DEPTH = DAM_LAT_SECOND_HALF;          // Stages held
   // Stage read by the output latch at the edge that ends each latency
   localparam int DAM_TAP_FIRST = DAM_LAT_FIRST_HALF - 1;
   localparam int DAM_TAP_SECOND = DAM_LAT_SECOND_HALF - 1;

   // Coding: offset binary, bipolar zero at the mid code
   localparam logic [7:0] DAM_ZERO_CODE = 8'h80;
   localparam logic [8:0] DAM_RAW_MAX = 9'h07f;   // +127 in two's complement
   localparam logic [8:0] DAM_RAW_MIN = 9'h180;   // -128 in two's complement

   // Values after reset
   localparam logic [7:0] DAM_BUS_RST = 8'h00;
   localparam logic [15:0] DAM_PAIR_RST = 16'h0000;
   localparam logic [2:0] DAM_SYNC_RST = 3'h0;

   // Power modes, encoded as {select_low, select_high}
   typedef enum logic [1:0] {
      DAM_SHUTDOWN = 2'b00,
      DAM_STANDBY = 2'b01,
      DAM_IDLE = 2'b10,
      DAM_NORMAL = 2'b11
   } dam_mode_t;

endpackage

// file: dam_stage_pipe.sv
/*
 * Stage chain: a shift line of channel pairs, moved one stage per shift strobe.
 * Assumes the strobe comes once per converter half period and only while converting.
 */
`timescale 1ns/10ps

module dam_stage_pipe
   import dam_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Shift side
   input wire logic i_shift,
   input wire logic [DAM_PAIR_W-1:0] i_word,
   // Taps, straight from stage registers
   output logic [DAM_PAIR_W-1:0] o_tap_first,
   output logic [DAM_PAIR_W-1:0] o_tap_second
);

   logic [DAM_PAIR_W-1:0] stage_reg [DAM_PIPE_DEPTH];   // Stage contents
   logic [DAM_PAIR_W-1:0] stage_next [DAM_PIPE_DEPTH];  // Next contents

   // Entry stage takes the new word on a shift
   always_comb begin
      stage_next[0] = i_shift ? i_word : stage_reg[0];
   end

   // Later stages take their neighbour on a shift
   genvar g;
   generate
      for (g = 1; g < DAM_PIPE_DEPTH; g++) begin : g_stage
         always_comb begin
            stage_next[g] = i_shift ? stage_reg[g-1] : stage_reg[g];
         end
      end
   endgenerate

   // Register every stage
   always_ff @(posedge i_clk) begin
      for (int k = 0; k < DAM_PIPE_DEPTH; k++) begin
         stage_reg[k] <= i_rst ? DAM_PAIR_RST : stage_next[k];
      end
   end

   // Read data come out of the stage registers
   assign o_tap_first = stage_reg[DAM_TAP_FIRST];
   assign o_tap_second = stage_reg[DAM_TAP_SECOND];

endmodule // dam_stage_pipe

// file: dam_top.sv
/*
 * Digital output side of a dual-channel 8-bit pipelined converter: both channels
 * sampled on the converter clock rising edge, pipelined by half periods, and
 * multiplexed onto one tri-state bus with a channel indicator.
 * Assumes the converter clock and power-select pins are asynchronous and slow
 * against i_clk (at least eight i_clk periods per converter half period).
 */
`timescale 1ns/10ps

module dam_top
   import dam_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Converter clock pin, asynchronous
   input wire logic i_conv_clk,
   // Power-select pins, asynchronous
   input wire logic i_power_select_low,
   input wire logic i_power_select_high,
   // Raw stage sums per channel, signed, on i_clk
   input wire logic [DAM_RAW_W-1:0] i_first_channel,
   input wire logic [DAM_RAW_W-1:0] i_second_channel,
   // Shared sample bus, tri-state as out/enable
   output logic [DAM_CODE_W-1:0] o_sample_bus,
   output logic o_sample_bus_oe,
   // Channel indicator
   output logic o_first_channel_flag
);

   // Correct a raw stage sum and code it as offset binary
   function automatic logic [DAM_CODE_W-1:0] corr_code(input logic [DAM_RAW_W-1:0] raw);
      logic [DAM_RAW_W-1:0] lim;
      lim = raw;
      // Clamp the redundant range to the 8-bit span
      if ($signed(raw) > $signed(DAM_RAW_MAX)) begin
         lim = DAM_RAW_MAX;
      end else if ($signed(raw) < $signed(DAM_RAW_MIN)) begin
         lim = DAM_RAW_MIN;
      end
      // Flip the sign so zero lands on the mid code
      return lim[DAM_CODE_W-1:0] ^ DAM_ZERO_CODE;
   endfunction

   // Pipeline and sampling run in idle and normal modes only
   function automatic logic mode_converts(input dam_mode_t m);
      return (m == DAM_IDLE) || (m == DAM_NORMAL);
   endfunction

   // Bus drivers are on in normal mode only
   function automatic logic mode_drives(input dam_mode_t m);
      return m == DAM_NORMAL;
   endfunction

   // Pin synchronisers, three flops each
   logic [2:0] clk_sync_reg;       // Converter clock chain
   logic [2:0] clk_sync_next;
   logic [2:0] psl_sync_reg;       // Select-low chain
   logic [2:0] psl_sync_next;
   logic [2:0] psh_sync_reg;       // Select-high chain
   logic [2:0] psh_sync_next;

   // Accepted pin levels
   logic clk_lvl_reg;              // Converter clock phase in force
   logic clk_lvl_next;
   logic psl_lvl_reg;              // Accepted select-low level
   logic psl_lvl_next;
   logic psh_lvl_reg;              // Accepted select-high level
   logic psh_lvl_next;

   // Mode and data path state
   dam_mode_t mode_reg;            // Current power mode
   dam_mode_t mode_next;
   logic [DAM_PAIR_W-1:0] hold_reg;   // Pair sampled at the last rising edge
   logic [DAM_PAIR_W-1:0] hold_next;
   logic [DAM_CODE_W-1:0] bus_reg;    // Output latch, keeps last word
   logic [DAM_CODE_W-1:0] bus_next;
   logic oe_reg;                      // Bus drive enable
   logic oe_next;
   logic flag_reg;                    // Channel indicator
   logic flag_next;

   // Edge events and pipe wiring
   logic rise_evt;                 // Accepted converter clock rising edge
   logic fall_evt;                 // Accepted converter clock falling edge
   logic converting;               // Sampling and stages active
   logic pipe_shift;               // One stage step
   logic [DAM_PAIR_W-1:0] pipe_in;    // Word entering the first stage
   logic [DAM_PAIR_W-1:0] tap_first;  // Pair ready for the first-channel latch
   logic [DAM_PAIR_W-1:0] tap_second; // Pair ready for the second-channel latch

   // Synchroniser shifts; only the second and third flops are compared
   always_comb begin
      // Each pin moves one flop further along its chain
      clk_sync_next = {clk_sync_reg[1:0], i_conv_clk};
      psl_sync_next = {psl_sync_reg[1:0], i_power_select_low};
      psh_sync_next = {psh_sync_reg[1:0], i_power_select_high};
      // Accepted levels hold until a chain has settled
      clk_lvl_next = clk_lvl_reg;
      psl_lvl_next = psl_lvl_reg;
      psh_lvl_next = psh_lvl_reg;
      // A change counts once the second and third flops agree
      if (clk_sync_reg[1] == clk_sync_reg[2]) begin
         clk_lvl_next = clk_sync_reg[2];
      end
      if (psl_sync_reg[1] == psl_sync_reg[2]) begin
         psl_lvl_next = psl_sync_reg[2];
      end
      if (psh_sync_reg[1] == psh_sync_reg[2]) begin
         psh_lvl_next = psh_sync_reg[2];
      end
   end

   // Register the synchronisers and accepted levels
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Empty the chains; the clock phase starts low
         clk_sync_reg <= DAM_SYNC_RST;
         psl_sync_reg <= DAM_SYNC_RST;
         psh_sync_reg <= DAM_SYNC_RST;
         clk_lvl_reg <= 1'b0;
         psl_lvl_reg <= 1'b0;
         psh_lvl_reg <= 1'b0;
      end else begin
         // Shift the chains and take the accepted levels
         clk_sync_reg <= clk_sync_next;
         psl_sync_reg <= psl_sync_next;
         psh_sync_reg <= psh_sync_next;
         clk_lvl_reg <= clk_lvl_next;
         psl_lvl_reg <= psl_lvl_next;
         psh_lvl_reg <= psh_lvl_next;
      end
   end

   // Edge events from the accepted converter clock
   assign rise_evt = clk_lvl_next & ~clk_lvl_reg;
   assign fall_evt = ~clk_lvl_next & clk_lvl_reg;
   assign converting = mode_converts(mode_reg);
   // Stages freeze outside idle and normal, so the pipe keeps its words
   assign pipe_shift = (rise_evt | fall_evt) & converting;

   // Both channels enter together on a rising edge; held pair refills on falling
   // The falling-edge copy only pads the half-period slot; it is tapped only after a conversion pause skips an odd number of edges
   assign pipe_in = rise_evt ?
      {corr_code(i_first_channel), corr_code(i_second_channel)} : hold_reg;

   // Stage chain, one step per half period
   // Taps come from stage registers, so the latch reads settled data
   dam_stage_pipe u_pipe (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_shift(pipe_shift),
      .i_word(pipe_in),
      .o_tap_first(tap_first),
      .o_tap_second(tap_second)
   );

   // Next mode, sample hold, output latch, enable and indicator
   always_comb begin
      // Mode follows the accepted pins; hold, latch and indicator hold by default
      mode_next = dam_mode_t'({psl_lvl_reg, psh_lvl_reg});
      hold_next = hold_reg;
      bus_next = bus_reg;
      flag_next = flag_reg;
      // Bus drives only in normal mode; tri-state otherwise
      oe_next = mode_drives(mode_reg);
      // Capture the pair at the sampling edge
      if (rise_evt && converting) begin
         hold_next = pipe_in;
      end
      // First channel word after ten half periods, on a rising edge
      if (rise_evt && converting) begin
         bus_next = tap_first[DAM_PAIR_W-1:DAM_CODE_W];
      end
      // Second channel word after eleven half periods, on a falling edge
      if (fall_evt && converting) begin
         bus_next = tap_second[DAM_CODE_W-1:0];
      end
      // Indicator follows the clock phase
      if (rise_evt) begin
         flag_next = 1'b1;
      end else if (fall_evt) begin
         flag_next = 1'b0;
      end
   end

   // Register mode and outputs; latch keeps its word through shutdown and standby
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Shut down with the bus released and the latch cleared
         mode_reg <= DAM_SHUTDOWN;
         hold_reg <= DAM_PAIR_RST;
         bus_reg <= DAM_BUS_RST;
         oe_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         // Take the next mode, latch word, enable and indicator
         mode_reg <= mode_next;
         hold_reg <= hold_next;
         bus_reg <= bus_next;
         oe_reg <= oe_next;
         flag_reg <= flag_next;
      end
   end

   // Outputs straight from flops
   assign o_sample_bus = bus_reg;
   assign o_sample_bus_oe = oe_reg;
   assign o_first_channel_flag = flag_reg;

endmodule // dam_top

// file: dam_chk.sv
/* Port checker for dam_top.
   Assumes bind from the bench and converter half periods of 8 clocks or more. */
`timescale 1ns/10ps
module dam_chk
   import dam_pkg::*;
(
   // Watched ports
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_conv_clk,
   input wire logic i_power_select_low,
   input wire logic i_power_select_high,
   input wire logic [DAM_CODE_W-1:0] o_sample_bus,
   input wire logic o_sample_bus_oe,
   input wire logic o_first_channel_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Normal mode decode
   wire both_hi = i_power_select_low && i_power_select_high;
   property p_oe_off; (!both_hi)[*8] |=> !o_sample_bus_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("bus driven outside normal mode");
   property p_oe_on; both_hi[*8] |=> o_sample_bus_oe; endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("bus not driven in normal mode");
   property p_flag_hi; i_conv_clk[*6] |=> o_first_channel_flag; endproperty
   a_flag_hi: assert property (p_flag_hi)
      else $error("flag low in high clock phase");
   property p_flag_lo; (!i_conv_clk)[*6] |=> !o_first_channel_flag; endproperty
   a_flag_lo: assert property (p_flag_lo)
      else $error("flag high in low clock phase");
   property p_flag_rose; $rose(o_first_channel_flag) |-> $past(i_conv_clk, 3); endproperty
   a_flag_rose: assert property (p_flag_rose)
      else $error("flag rose without clock rise");
   property p_flag_fell; $fell(o_first_channel_flag) |-> !$past(i_conv_clk, 3); endproperty
   a_flag_fell: assert property (p_flag_fell)
      else $error("flag fell without clock fall");
   property p_frozen; (!i_power_select_low)[*8] |=> $stable(o_sample_bus); endproperty
   a_frozen: assert property (p_frozen)
      else $error("bus moved while conversion stopped");
   property p_edge; $changed(o_sample_bus) |-> $past(i_conv_clk, 3) != $past(i_conv_clk, 6);
   endproperty
   a_edge: assert property (p_edge)
      else $error("bus changed away from a clock edge");
   // Main scenarios
   c_first: cover property (o_sample_bus_oe && o_first_channel_flag);
   c_second: cover property (o_sample_bus_oe && !o_first_channel_flag);
   c_wake: cover property ($rose(o_sample_bus_oe));
endmodule // dam_chk

// file: dam_rx_model.sv
/* Receiving logic model: supplies the converter clock and latches bus words.
   Assumes one word is latched late in each converter half period. */
`timescale 1ns/10ps
module dam_rx_model #(
   parameter int HALF = 10
) (
   // Clock and run enable
   input wire logic i_clk,
   input wire logic i_run,
   // Bus side
   input wire logic [7:0] i_bus,
   input wire logic i_flag,
   // Clock out and latched words
   output logic o_conv_clk = 1'b0,
   output logic o_strobe = 1'b0,
   output logic [7:0] o_word,
   output logic o_flag
);
   int cnt = 0;
   // Equal halves; clock stands low while not running
   always @(posedge i_clk) begin
      o_strobe <= 1'b0;
      if (!i_run) begin
         cnt <= 0;
         o_conv_clk <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         o_conv_clk <= ~o_conv_clk;
      end else begin
         cnt <= cnt + 1;
      end
      if (i_run && cnt == HALF - 2) begin
         o_strobe <= 1'b1;
         o_word <= i_bus;
         o_flag <= i_flag;
      end
   end
endmodule // dam_rx_model

// file: tb_dual_adc_muxed_output_timing.sv
/* Self-checking bench for dam_top with the receiver model.
   Assumes the checker and package compile first. */
`timescale 1ns/10ps
module tb_dual_adc_muxed_output_timing;
   import dam_pkg::*;
   localparam int HALF = 10;
   logic i_clk = 1'b0, i_rst = 1'b1, pin_low = 1'b0, pin_high = 1'b0, run = 1'b0;
   logic conv_clk, strobe, cap_flag, oe, flag;
   logic [7:0] bus, cap_word, held;
   logic [8:0] tab [8] = '{9'h000, 9'h07f, 9'h180, 9'h0c8, 9'h138, 9'h001, 9'h1ff, 9'h055};
   int n = 0, n_fail = 0, tests_run = 0;
   wire [7:0] bus_w = oe ? bus : 8'hzz;
   dam_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_conv_clk(conv_clk),
      .i_power_select_low(pin_low), .i_power_select_high(pin_high),
      .i_first_channel(tab[n % 8]), .i_second_channel(tab[(n + 3) % 8]),
      .o_sample_bus(bus), .o_sample_bus_oe(oe), .o_first_channel_flag(flag));
   dam_rx_model #(.HALF(HALF)) rx (.i_clk(i_clk), .i_run(run), .i_bus(bus_w), .i_flag(flag),
      .o_conv_clk(conv_clk), .o_strobe(strobe), .o_word(cap_word), .o_flag(cap_flag));
   initial forever #20 i_clk = ~i_clk;
   // Count samples taken
   always @(posedge conv_clk) begin
      #1;
      n = n + 1;
   end
   function automatic logic [7:0] code(input logic [8:0] r);
      if ($signed(r) > 9'sd127) return 8'hff;
      if ($signed(r) < -9'sd128) return 8'h00;
      return r[7:0] ^ 8'h80;
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic next_strobe;
      for (int i = 0; i < 4 * HALF; i++) begin
         @(posedge i_clk);
         #1;
         if (strobe) return;
      end
      check(8'h00, 8'h01);
      print_verdict;
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(posedge i_clk);
      #1;
      {pin_low, pin_high} = m;
   endtask
   // Compare each latched word with the sample from five cycles back
   task automatic stream_check(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         next_strobe;
         check({7'h0, cap_flag}, {7'h0, conv_clk});
         check(cap_word, cap_flag ? code(tab[(n - 5) % 8]) : code(tab[(n - 2) % 8]));
      end
   endtask
   task automatic t_stream;
      set_mode(2'b11);
      repeat (14) next_strobe;
      check({7'h0, oe}, 8'h01);
      stream_check(24);
   endtask
   task automatic t_power;
      for (int m = 0; m < 3; m++) begin
         set_mode(m[1:0]);
         repeat (2) next_strobe;
         check({7'h0, oe}, 8'h00);
      end
      set_mode(2'b01);
      repeat (2) next_strobe;
      held = bus;
      repeat (4) next_strobe;
      check(bus, held);
      // Standby straight to normal: the frozen word must come back on the bus
      set_mode(2'b11);
      repeat (6) @(posedge i_clk);
      #1;
      check({7'h0, oe}, 8'h01);
      check(bus_w, held);
      set_mode(2'b10);
      repeat (14) next_strobe;
      set_mode(2'b11);
      repeat (6) @(posedge i_clk);
      stream_check(4);
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      run = 1'b1;
      check({7'h0, oe}, 8'h00);
      t_stream;
      t_power;
      print_verdict;
   end
endmodule // tb_dual_adc_muxed_output_timing
bind dam_top dam_chk chk (.i_clk(i_clk), .i_rst(i_rst), .i_conv_clk(i_conv_clk),
   .i_power_select_low(i_power_select_low), .i_power_select_high(i_power_select_high),
   .o_sample_bus(o_sample_bus), .o_sample_bus_oe(o_sample_bus_oe),
   .o_first_channel_flag(o_first_channel_flag));
